// ==== core/rts_pkg.sv ====
// constants and types shared by the reset timeout sequencer
package rts_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned POWERUP_DELAY_MS = 64;
  localparam int unsigned RC_OSC_HZ = 31_250;
  localparam int unsigned POWERUP_TICKS = POWERUP_DELAY_MS * RC_OSC_HZ / 1000;
  localparam int unsigned OSC_STARTUP_PERIODS = 1024;
  localparam int unsigned BROWNOUT_MIN_NS = 100_000;
  // least time: round up to whole clock cycles
  localparam int unsigned BROWNOUT_MIN_CYCLES =
    (BROWNOUT_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned CNT_W = 16;

  localparam int unsigned ADR_W = 12;
  localparam logic [9:0] PWR_CTRL_IDX = 10'h08E;
  localparam logic [9:0] STATUS_IDX = 10'h003;
  localparam logic [9:0] CONTROL_IDX = 10'h004;
  localparam logic [9:0] STATE_IDX = 10'h005;

  localparam int unsigned PC_BOR_BIT = 0;
  localparam int unsigned PC_POR_BIT = 1;
  localparam int unsigned ST_TO_BIT = 4;
  localparam int unsigned ST_PD_BIT = 3;
  localparam int unsigned CTL_SLEEP_BIT = 0;
  localparam int unsigned CTL_CLRWDT_BIT = 1;

  localparam logic [2:0] STATUS_HI_RESET = 3'h0;
  localparam logic [2:0] STATUS_LO_RESET = 3'h0;
  localparam logic FLAG_RESET = 1'h0;

  localparam logic [1:0] BOR_MODE_SLEEP_OFF = 2'h2;
  localparam logic [1:0] BOR_MODE_ON = 2'h3;

  localparam logic [1:0] OSC_CRYSTAL = 2'h0;
  localparam logic [1:0] OSC_RC = 2'h1;
  localparam logic [1:0] OSC_EXT = 2'h2;
  localparam logic [1:0] OSC_INT = 2'h3;

  localparam int unsigned SYNC_W = 6;
  localparam int unsigned SY_POR = 0;
  localparam int unsigned SY_VDD = 1;
  localparam int unsigned SY_PIN = 2;
  localparam int unsigned SY_RC = 3;
  localparam int unsigned SY_XTAL = 4;
  localparam int unsigned SY_WDT = 5;
  localparam logic [5:0] SYNC_RESET = 6'h04;

  typedef enum logic [2:0] {
    ST_POR, ST_WAIT_VDD, ST_POWERUP_DELAY_TIMER, ST_OST, ST_RUN, ST_SLEEP, ST_WAKE_OST
  } rts_state_t;
endpackage

// ==== core/rts_cnt_if.sv ====
// request and status lines between the sequencer and a delay counter
interface rts_cnt_if;
  logic start;
  logic tick;
  logic [rts_pkg::CNT_W-1:0] limit;
  logic busy;
  logic done;
  modport ctrl (output start, output tick, output limit,
                input busy, input done);
  modport cnt (input start, input tick, input limit,
               output busy, output done);
endinterface

// ==== core/rts_delay_counter.sv ====
// restartable tick counter used for the power-up delay and start-up count
module rts_delay_counter (
  input wire logic clk,
  input wire logic arst_n,
  rts_cnt_if.cnt cnt
);
  logic [rts_pkg::CNT_W-1:0] count_reg;
  logic [rts_pkg::CNT_W-1:0] count_next;
  logic busy_reg;
  logic busy_next;
  logic done_reg;
  logic done_next;

  assign cnt.busy = busy_reg;
  assign cnt.done = done_reg;

  always_comb begin
    count_next = count_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    if (cnt.start) begin
      // a restart throws away any partial count
      count_next = '0;
      busy_next = 1'b1;
    end else if (busy_reg && cnt.tick) begin
      count_next = count_reg + 1'b1;
      if (count_next >= cnt.limit) begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end
endmodule

// ==== core/rts_sequencer.sv ====
// reset timeout sequencer with reset-cause flags on a wishbone slave
//
// Chosen here: the Wishbone interface to the registers.
module rts_sequencer #(
  parameter int unsigned POWERUP_TICKS = rts_pkg::POWERUP_TICKS,
  parameter int unsigned BROWNOUT_MIN_CYCLES = rts_pkg::BROWNOUT_MIN_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic por_detect_n,
  input wire logic vdd_above_threshold,
  input wire logic external_reset_pin_n,
  input wire logic rc_osc_in,
  input wire logic xtal_osc_in,
  input wire logic watchdog_timeout,
  input wire logic wake_event,
  input wire logic powerup_delay_disable,
  input wire logic [1:0] brownout_mode_select,
  input wire logic external_reset_pin_enable,
  input wire logic [1:0] osc_mode,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [rts_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic core_reset,
  output logic core_stall,
  output logic brownout_detector_enable
);
  function automatic logic hits(input logic [rts_pkg::ADR_W-1:0] adr,
                                input logic [9:0] idx);
    hits = (adr[rts_pkg::ADR_W-1:2] == idx);
  endfunction

  // three stages: the first is read only by the second
  logic [rts_pkg::SYNC_W-1:0] sy1_reg;
  logic [rts_pkg::SYNC_W-1:0] sy2_reg;
  logic [rts_pkg::SYNC_W-1:0] sy3_reg;
  logic [rts_pkg::SYNC_W-1:0] sy_in;
  logic por_active;
  logic vdd_ok;
  logic pin_active;
  logic rc_tick;
  logic xtal_tick;
  logic wdt_event;

  assign sy_in = {watchdog_timeout, xtal_osc_in, rc_osc_in,
                  external_reset_pin_n, vdd_above_threshold, por_detect_n};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sy1_reg <= rts_pkg::SYNC_RESET;
      sy2_reg <= rts_pkg::SYNC_RESET;
      sy3_reg <= rts_pkg::SYNC_RESET;
    end else begin
      sy1_reg <= sy_in;
      sy2_reg <= sy1_reg;
      sy3_reg <= sy2_reg;
    end
  end

  assign por_active = !sy2_reg[rts_pkg::SY_POR];
  assign vdd_ok = sy2_reg[rts_pkg::SY_VDD];
  // pin only counts as a reset input when enabled
  assign pin_active = external_reset_pin_enable
                      && !sy2_reg[rts_pkg::SY_PIN];
  // the power-up delay advances on RC oscillator edges
  assign rc_tick = sy2_reg[rts_pkg::SY_RC] && !sy3_reg[rts_pkg::SY_RC];
  assign xtal_tick = sy2_reg[rts_pkg::SY_XTAL]
                     && !sy3_reg[rts_pkg::SY_XTAL];
  assign wdt_event = sy2_reg[rts_pkg::SY_WDT] && !sy3_reg[rts_pkg::SY_WDT];

  // delay counters
  rts_cnt_if powerup_delay_timer_if ();
  rts_cnt_if ost_if ();

  rts_delay_counter u_powerup_delay_timer (
    .clk(clk),
    .arst_n(arst_n),
    .cnt(powerup_delay_timer_if)
  );

  rts_delay_counter u_osc_startup_counter (
    .clk(clk),
    .arst_n(arst_n),
    .cnt(ost_if)
  );

  assign powerup_delay_timer_if.tick = rc_tick;
  assign powerup_delay_timer_if.limit = rts_pkg::CNT_W'(POWERUP_TICKS);
  assign ost_if.tick = xtal_tick;
  assign ost_if.limit = rts_pkg::CNT_W'(rts_pkg::OSC_STARTUP_PERIODS);

  // brown-out filter
  rts_pkg::rts_state_t state_reg;
  rts_pkg::rts_state_t state_next;
  logic [rts_pkg::CNT_W-1:0] low_cnt_reg;
  logic [rts_pkg::CNT_W-1:0] low_cnt_next;
  logic bor_en_reg;
  logic bor_en_next;
  logic bor_event;

  always_comb begin
    // mode 10 drops the detector while asleep to save current
    bor_en_next = (brownout_mode_select == rts_pkg::BOR_MODE_ON)
                  || (brownout_mode_select == rts_pkg::BOR_MODE_SLEEP_OFF
                      && state_next != rts_pkg::ST_SLEEP);
    low_cnt_next = low_cnt_reg;
    bor_event = 1'b0;
    if (!bor_en_reg || vdd_ok) begin
      low_cnt_next = '0;
    end else if (low_cnt_reg < rts_pkg::CNT_W'(BROWNOUT_MIN_CYCLES)) begin
      low_cnt_next = low_cnt_reg + 1'b1;
      // short dips never reach the limit
      bor_event = (low_cnt_next == rts_pkg::CNT_W'(BROWNOUT_MIN_CYCLES));
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      low_cnt_reg <= '0;
      bor_en_reg <= 1'b0;
    end else begin
      low_cnt_reg <= low_cnt_next;
      bor_en_reg <= bor_en_next;
    end
  end

  assign brownout_detector_enable = bor_en_reg;

  // bus request decode
  logic req;
  logic wr_stb;
  logic ack_reg;
  logic ack_next;
  logic [31:0] dat_reg;
  logic [31:0] dat_next;
  logic sleep_cmd;
  logic clrwdt_cmd;

  assign req = wb_cyc_i && wb_stb_i;
  // writes land on the edge where the master sees ack
  assign wr_stb = req && wb_we_i && ack_reg && wb_sel_i[0];
  assign sleep_cmd = wr_stb && hits(wb_adr_i, rts_pkg::CONTROL_IDX)
                     && wb_dat_i[rts_pkg::CTL_SLEEP_BIT];
  assign clrwdt_cmd = wr_stb && hits(wb_adr_i, rts_pkg::CONTROL_IDX)
                      && wb_dat_i[rts_pkg::CTL_CLRWDT_BIT];

  // sequencer and reset-cause state
  logic cold_reg;
  logic cold_next;
  logic por_flag_n_reg;
  logic por_flag_n_next;
  logic bor_flag_n_reg;
  logic bor_flag_n_next;
  logic to_flag_n_reg;
  logic to_flag_n_next;
  logic pd_flag_n_reg;
  logic pd_flag_n_next;
  logic [2:0] status_hi_reg;
  logic [2:0] status_hi_next;
  logic [2:0] status_lo_reg;
  logic [2:0] status_lo_next;
  logic core_reset_reg;
  logic core_reset_next;
  logic crystal;
  logic delay_en;

  assign crystal = (osc_mode == rts_pkg::OSC_CRYSTAL);
  assign delay_en = !powerup_delay_disable;

  always_comb begin
    state_next = state_reg;
    cold_next = cold_reg;
    por_flag_n_next = por_flag_n_reg;
    bor_flag_n_next = bor_flag_n_reg;
    to_flag_n_next = to_flag_n_reg;
    pd_flag_n_next = pd_flag_n_reg;
    status_hi_next = status_hi_reg;
    status_lo_next = status_lo_reg;
    powerup_delay_timer_if.start = 1'b0;
    ost_if.start = 1'b0;

    // software first, so any hardware event below wins the same cycle
    if (wr_stb && hits(wb_adr_i, rts_pkg::PWR_CTRL_IDX)) begin
      por_flag_n_next = wb_dat_i[rts_pkg::PC_POR_BIT];
      bor_flag_n_next = wb_dat_i[rts_pkg::PC_BOR_BIT];
    end
    if (wr_stb && hits(wb_adr_i, rts_pkg::STATUS_IDX)) begin
      status_hi_next = wb_dat_i[7:5];
      status_lo_next = wb_dat_i[2:0];
    end

    if (por_active) begin
      // power-on: flags forced regardless of anything else
      state_next = rts_pkg::ST_POR;
      cold_next = 1'b1;
      por_flag_n_next = 1'b0;
      to_flag_n_next = 1'b1;
      pd_flag_n_next = 1'b1;
    end else if (bor_event) begin
      // also aborts a running delay, which restarts later
      state_next = rts_pkg::ST_WAIT_VDD;
      cold_next = 1'b1;
      bor_flag_n_next = 1'b0;
      to_flag_n_next = 1'b1;
      pd_flag_n_next = 1'b1;
    end else if (pin_active && state_reg == rts_pkg::ST_SLEEP) begin
      to_flag_n_next = 1'b1;
      pd_flag_n_next = 1'b0;
      state_next = rts_pkg::ST_RUN;
    end else begin
      case (state_reg)
        rts_pkg::ST_POR: begin
          state_next = rts_pkg::ST_WAIT_VDD;
        end
        rts_pkg::ST_WAIT_VDD: begin
          if (vdd_ok) begin
            if (cold_reg && delay_en) begin
              state_next = rts_pkg::ST_POWERUP_DELAY_TIMER;
              powerup_delay_timer_if.start = 1'b1;
            end else if (cold_reg && crystal) begin
              state_next = rts_pkg::ST_OST;
              ost_if.start = 1'b1;
            end else begin
              // a warm restart, or a non-crystal clock with no delay, releases at once
              state_next = rts_pkg::ST_RUN;
            end
          end
        end
        rts_pkg::ST_POWERUP_DELAY_TIMER: begin
          if (!vdd_ok) begin
            state_next = rts_pkg::ST_WAIT_VDD;
          end else if (powerup_delay_timer_if.done) begin
            if (crystal) begin
              state_next = rts_pkg::ST_OST;
              ost_if.start = 1'b1;
            end else begin
              state_next = rts_pkg::ST_RUN;
            end
          end
        end
        rts_pkg::ST_OST, rts_pkg::ST_WAKE_OST: begin
          if (ost_if.done) begin
            state_next = rts_pkg::ST_RUN;
          end
        end
        rts_pkg::ST_RUN: begin
          if (wdt_event) begin
            // watchdog reset is internal only; pin is never driven
            to_flag_n_next = 1'b0;
            state_next = rts_pkg::ST_WAIT_VDD;
            cold_next = 1'b0;
          end else if (sleep_cmd) begin
            to_flag_n_next = 1'b1;
            pd_flag_n_next = 1'b0;
            state_next = rts_pkg::ST_SLEEP;
          end else if (clrwdt_cmd) begin
            to_flag_n_next = 1'b1;
            pd_flag_n_next = 1'b1;
          end
        end
        rts_pkg::ST_SLEEP: begin
          if (wdt_event || wake_event) begin
            if (wdt_event) begin
              to_flag_n_next = 1'b0;
              pd_flag_n_next = 1'b0;
            end
            if (crystal) begin
              state_next = rts_pkg::ST_WAKE_OST;
              ost_if.start = 1'b1;
            end else begin
              state_next = rts_pkg::ST_RUN;
            end
          end
        end
        default: begin
          state_next = rts_pkg::ST_POR;
        end
      endcase
    end

    // outside ST_SLEEP the pin only stretches the reset, the timers run on beneath it; in sleep it also wakes to ST_RUN
    core_reset_next = pin_active
                      || (state_next != rts_pkg::ST_RUN
                          && state_next != rts_pkg::ST_SLEEP
                          && state_next != rts_pkg::ST_WAKE_OST);
    if (core_reset_next) begin
      status_hi_next = rts_pkg::STATUS_HI_RESET;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= rts_pkg::ST_POR;
      cold_reg <= 1'b1;
      por_flag_n_reg <= rts_pkg::FLAG_RESET;
      bor_flag_n_reg <= rts_pkg::FLAG_RESET;
      to_flag_n_reg <= 1'b1;
      pd_flag_n_reg <= 1'b1;
      status_hi_reg <= rts_pkg::STATUS_HI_RESET;
      status_lo_reg <= rts_pkg::STATUS_LO_RESET;
      core_reset_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      cold_reg <= cold_next;
      por_flag_n_reg <= por_flag_n_next;
      bor_flag_n_reg <= bor_flag_n_next;
      to_flag_n_reg <= to_flag_n_next;
      pd_flag_n_reg <= pd_flag_n_next;
      status_hi_reg <= status_hi_next;
      status_lo_reg <= status_lo_next;
      core_reset_reg <= core_reset_next;
    end
  end

  assign core_reset = core_reset_reg;
  assign core_stall = (state_reg == rts_pkg::ST_SLEEP)
                      || (state_reg == rts_pkg::ST_WAKE_OST);

  // bus slave: one wait state, unmapped reads return zero
  always_comb begin
    ack_next = req && !ack_reg;
    dat_next = dat_reg;
    if (req && !ack_reg) begin
      dat_next = 32'h0000_0000;
      if (hits(wb_adr_i, rts_pkg::PWR_CTRL_IDX)) begin
        // bits above the two flags read zero
        dat_next[rts_pkg::PC_POR_BIT] = por_flag_n_reg;
        dat_next[rts_pkg::PC_BOR_BIT] = bor_flag_n_reg;
      end else if (hits(wb_adr_i, rts_pkg::STATUS_IDX)) begin
        dat_next[7:5] = status_hi_reg;
        dat_next[rts_pkg::ST_TO_BIT] = to_flag_n_reg;
        dat_next[rts_pkg::ST_PD_BIT] = pd_flag_n_reg;
        dat_next[2:0] = status_lo_reg;
      end else if (hits(wb_adr_i, rts_pkg::STATE_IDX)) begin
        dat_next[2:0] = state_reg;
        dat_next[3] = core_reset_reg;
        dat_next[4] = bor_en_reg;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= ack_next;
      dat_reg <= dat_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
endmodule

// ==== testbench/rts_osc_model.sv ====
// free-running internal rc and crystal oscillators seen by the sequencer
module rts_osc_model #(
  parameter int RC_HALF = 100,
  parameter int XT_HALF = 53
) (
  output logic rc_osc_in,
  output logic xtal_osc_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // both run from power-up; phases unrelated to the system clock
  initial rc_osc_in = 1'b0;
  initial xtal_osc_in = 1'b0;
  always #(RC_HALF) rc_osc_in = ~rc_osc_in;
  always #(XT_HALF) xtal_osc_in = ~xtal_osc_in;
endmodule

// ==== testbench/rts_sequencer_checker.sv ====
// concurrent checks on the reset timeout sequencer ports
module rts_sequencer_checker #(
  parameter int unsigned BROWNOUT_MIN_CYCLES = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic por_detect_n,
  input wire logic vdd_above_threshold,
  input wire logic external_reset_pin_n,
  input wire logic watchdog_timeout,
  input wire logic [1:0] brownout_mode_select,
  input wire logic external_reset_pin_enable,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [rts_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic core_reset,
  input wire logic core_stall,
  input wire logic brownout_detector_enable
);
  // margin covers the input synchroniser and the registered reset
  localparam int unsigned LIM = BROWNOUT_MIN_CYCLES + 6;
  logic [15:0] low_cnt_reg, low_cnt_next;
  logic arm_reg, arm_next;
  always_comb begin
    low_cnt_next = 16'h0000;
    arm_next = 1'b0;
    if (!vdd_above_threshold) begin
      low_cnt_next = (low_cnt_reg == 16'hFFFF) ? low_cnt_reg
                     : low_cnt_reg + 16'h1;
      arm_next = (low_cnt_reg == 16'h0000) ?
        (brownout_detector_enable && !core_reset) : arm_reg;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      low_cnt_reg <= 16'h0000;
      arm_reg <= 1'b0;
    end else begin
      low_cnt_reg <= low_cnt_next;
      arm_reg <= arm_next;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_ack_follows_req: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  a_pc_upper_zero: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i[11:2] == rts_pkg::PWR_CTRL_IDX
    |-> wb_dat_o[31:2] == 30'h0) else $error("pc high bits set");
  a_por_holds_reset: assert property (
    !por_detect_n [*4] |-> core_reset) else $error("reset released in por");
  a_pin_holds_reset: assert property (
    (external_reset_pin_enable && !external_reset_pin_n) [*4] |-> core_reset)
    else $error("pin reset lost");
  a_vdd_low_wait: assert property (
    (!vdd_above_threshold && core_reset) [*3] |=> core_reset)
    else $error("released on low supply");
  a_brownout_fires: assert property (
    arm_reg && low_cnt_reg == LIM |-> core_reset)
    else $error("brown-out missed");
  a_bor_mode_off: assert property (
    !brownout_mode_select[1] && !core_reset |-> !brownout_detector_enable)
    else $error("detector on when off");
  // stall also covers the wake start-up count, where the detector is back on
  a_bor_sleep_off: assert property (
    brownout_mode_select == rts_pkg::BOR_MODE_SLEEP_OFF && $rose(core_stall)
    |-> !brownout_detector_enable) else $error("detector on in sleep");
  a_wdt_resets: assert property (
    !core_reset && !core_stall && $rose(watchdog_timeout)
    |-> ##[1:6] core_reset) else $error("watchdog reset missed");
endmodule
bind rts_sequencer rts_sequencer_checker #(
  .BROWNOUT_MIN_CYCLES(BROWNOUT_MIN_CYCLES)) u_chk (.clk, .arst_n,
  .por_detect_n, .vdd_above_threshold, .external_reset_pin_n,
  .watchdog_timeout, .brownout_mode_select, .external_reset_pin_enable,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o,
  .core_reset, .core_stall, .brownout_detector_enable);

// ==== testbench/tb_rts_sequencer.sv ====
// self-checking bench for the reset timeout sequencer
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
  fail_count++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module tb_rts_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PT = 4;
  localparam int BMC = 8;
  localparam int RCP = 200;
  localparam int XTP = 106;
  localparam logic [9:0] PC = rts_pkg::PWR_CTRL_IDX;
  localparam logic [9:0] ST = rts_pkg::STATUS_IDX;
  localparam logic [9:0] CT = rts_pkg::CONTROL_IDX;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic por_detect_n = 1'b0;
  logic vdd_above_threshold = 1'b1;
  logic external_reset_pin_n = 1'b1;
  logic watchdog_timeout = 1'b0;
  logic wake_event = 1'b0;
  logic powerup_delay_disable = 1'b0;
  logic external_reset_pin_enable = 1'b1;
  logic [1:0] brownout_mode_select = 2'h3;
  logic [1:0] osc_mode = 2'h1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [rts_pkg::ADR_W-1:0] wb_adr_i = 12'h000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] sel = 4'hF;
  logic [31:0] wb_dat_o, d;
  logic rc_osc_in, xtal_osc_in, wb_ack_o, core_reset, core_stall;
  logic brownout_detector_enable;
  logic [16:0] lf = 17'h1370B;
  int fail_count = 0;
  int tests_run = 0;
  int ns;
  // delay stays on wherever the detector is in use
  logic [1:0] t_o [5] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3};
  logic t_x [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  logic [1:0] t_b [5] = '{2'h3, 2'h0, 2'h3, 2'h1, 2'h3};
  always #10 clk = ~clk;
  rts_sequencer #(.POWERUP_TICKS(PT), .BROWNOUT_MIN_CYCLES(BMC)) DUT (
    .clk, .arst_n, .por_detect_n, .vdd_above_threshold,
    .external_reset_pin_n, .rc_osc_in, .xtal_osc_in, .watchdog_timeout,
    .wake_event, .powerup_delay_disable, .brownout_mode_select,
    .external_reset_pin_enable, .osc_mode, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .core_reset,
    .core_stall, .brownout_detector_enable);
  rts_osc_model #(.RC_HALF(RCP / 2), .XT_HALF(XTP / 2)) u_osc (
    .rc_osc_in, .xtal_osc_in);
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  // least time the sequencer may hold reset, plus a caller's slack
  function automatic int exp_ns(input logic [1:0] o, input logic x,
                                input int sl);
    return sl + (x ? 0 : (PT - 1) * RCP) +
      (o == rts_pkg::OSC_CRYSTAL ?
       (rts_pkg::OSC_STARTUP_PERIODS - 1) * XTP : 0);
  endfunction
  task automatic test_done();
    if (fail_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [9:0] i, input logic [31:0] v);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= {i, 2'h0};
    wb_sel_i <= sel;
    wb_dat_i <= v;
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    d = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic wait_rel(input int lim);
    ns = 0;
    do begin
      @(posedge clk);
      ns += 20;
    end while (core_reset !== 1'b0 && ns < lim);
  endtask
  task automatic boot(input logic [1:0] o, input logic x, input logic [1:0] b,
                      input logic pe, input int lim);
    arst_n <= 1'b0;
    por_detect_n <= 1'b0;
    osc_mode <= o;
    powerup_delay_disable <= x;
    brownout_mode_select <= b;
    external_reset_pin_enable <= pe;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge clk);
    por_detect_n <= 1'b1;
    wait_rel(lim);
  endtask
  task automatic vdd_low(input int n);
    vdd_above_threshold <= 1'b0;
    repeat (n) @(posedge clk);
    vdd_above_threshold <= 1'b1;
  endtask
  task automatic wdt_pulse();
    watchdog_timeout <= 1'b1;
    repeat (4) @(posedge clk);
    watchdog_timeout <= 1'b0;
  endtask
  initial begin
    #1_500_000;
    fail_count++;
    test_done();
  end
  initial begin
    for (int k = 0; k < 5; k++) begin
      boot(t_o[k], t_x[k], t_b[k], 1'b1, 200000);
      `CHK("boot_min", 1'b1, ns >= exp_ns(t_o[k], t_x[k], 0))
      `CHK("boot_max", 1'b1, ns <= exp_ns(t_o[k], t_x[k], 800))
    end
    external_reset_pin_n <= 1'b0;
    boot(2'h1, 1'b0, 2'h2, 1'b1, 3000);
    `CHK("pin_hold", 1'b1, core_reset)
    external_reset_pin_n <= 1'b1;
    wait_rel(400);
    `CHK("pin_late", 1'b1, ns <= 120)
    wb(1'b0, PC, 32'h0);
    `CHK("pc_por", 32'h0, d)
    wb(1'b0, ST, 32'h0);
    `CHK("st_por", 32'h18, d)
    wb(1'b1, PC, 32'hFF);
    wb(1'b0, PC, 32'h0);
    `CHK("pc_sw", 32'h3, d)
    // low byte lane off: the write must be ignored
    sel = 4'hE;
    wb(1'b1, PC, 32'h0);
    sel = 4'hF;
    wb(1'b0, PC, 32'h0);
    `CHK("sel_off", 32'h3, d)
    lf = lfsr(lf);
    wb(1'b1, ST, {15'h0, lf});
    wb(1'b0, ST, 32'h0);
    `CHK("st_rw", {24'h0, lf[7:5], 2'h3, lf[2:0]}, d)
    wb(1'b1, 10'h3FF, 32'hFF);
    wb(1'b0, 10'h3FF, 32'h0);
    `CHK("unmapped", 32'h0, d)
    wb(1'b0, rts_pkg::STATE_IDX, 32'h0);
    `CHK("run_state", 32'h14, d)
    lf = lfsr(lf);
    vdd_low(1 + lf % (BMC - 3));
    repeat (6) @(posedge clk);
    `CHK("dip", 1'b0, core_reset)
    vdd_low(BMC + 30);
    `CHK("bor_hold", 1'b1, core_reset)
    repeat (20) @(posedge clk);
    vdd_low(BMC + 6);
    wait_rel(2000);
    `CHK("bor_rerun", 1'b1, ns >= exp_ns(2'h1, 1'b0, 0))
    wb(1'b0, PC, 32'h0);
    `CHK("pc_bor", 32'h2, d)
    wb(1'b0, ST, 32'h0);
    `CHK("st_bor", 5'h03, d[7:3])
    wb(1'b1, PC, 32'h3);
    wdt_pulse();
    wait_rel(1000);
    `CHK("wdt_fast", 1'b1, ns < exp_ns(2'h1, 1'b0, 0))
    wb(1'b0, ST, 32'h0);
    `CHK("st_wdt", 2'h1, d[4:3])
    wb(1'b0, PC, 32'h0);
    `CHK("pc_wdt", 32'h3, d)
    wb(1'b1, CT, 32'h2);
    wb(1'b0, CT, 32'h0);
    `CHK("ct_read", 32'h0, d)
    wb(1'b0, ST, 32'h0);
    `CHK("st_clrwdt", 2'h3, d[4:3])
    wb(1'b1, CT, 32'h1);
    wb(1'b0, rts_pkg::STATE_IDX, 32'h0);
    `CHK("bor_sleep", 1'b0, d[4])
    wdt_pulse();
    repeat (8) @(posedge clk);
    `CHK("wdt_wake", 2'h0, {core_reset, core_stall})
    wb(1'b0, ST, 32'h0);
    `CHK("st_wake", 2'h0, d[4:3])
    wb(1'b1, CT, 32'h1);
    wake_event <= 1'b1;
    @(posedge clk);
    wake_event <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK("bor_wake", 1'b1, brownout_detector_enable)
    wb(1'b1, CT, 32'h1);
    external_reset_pin_n <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK("pin_sleep", 1'b1, core_reset)
    external_reset_pin_n <= 1'b1;
    wait_rel(400);
    wb(1'b0, ST, 32'h0);
    `CHK("st_pin_sl", 2'h2, d[4:3])
    external_reset_pin_n <= 1'b0;
    repeat (6) @(posedge clk);
    external_reset_pin_n <= 1'b1;
    wait_rel(400);
    wb(1'b0, ST, 32'h0);
    `CHK("st_pin", 2'h2, d[4:3])
    // crystal wake from sleep runs the start-up count with the core stalled
    boot(rts_pkg::OSC_CRYSTAL, 1'b1, 2'h2, 1'b1, 200000);
    wb(1'b1, CT, 32'h1);
    wake_event <= 1'b1;
    @(posedge clk);
    wake_event <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK("wake_ost", 2'h1, {core_reset, core_stall})
    `CHK("bor_ost", 1'b1, brownout_detector_enable)
    repeat (exp_ns(rts_pkg::OSC_CRYSTAL, 1'b1, 1000) / 20) @(posedge clk);
    `CHK("ost_end", 2'h0, {core_reset, core_stall})
    external_reset_pin_n <= 1'b0;
    boot(2'h2, 1'b1, 2'h0, 1'b0, 2000);
    `CHK("pin_off", 1'b0, core_reset)
    test_done();
  end
endmodule
